// ---- fpr_defines.vh ----
// Register offsets, field positions, reset values and constants of the packet receiver
`ifndef FPR_DEFINES_VH
`define FPR_DEFINES_VH
`define FPR_OFF_PKT_CFG      12'h108
`define FPR_OFF_SYNC_LO      12'h10C
`define FPR_OFF_SYNC_MID     12'h10D
`define FPR_OFF_SYNC_HI      12'h10E
`define FPR_OFF_SYNC_CFG     12'h10F
`define FPR_OFF_PRE_CFG      12'h111
`define FPR_OFF_RADIO_CFG    12'h13E
`define FPR_OFF_CORR_CFG     12'h305
`define FPR_OFF_PRE_QUAL     12'h3F3
`define FPR_OFF_FC_CFG       12'h3F7
`define FPR_OFF_RX_BASE      12'h400
`define FPR_OFF_EV_MASK_A    12'h401
`define FPR_OFF_EV_MASK_B    12'h402
`define FPR_OFF_STATUS       12'h403
`define FPR_OFF_RAM_RD       12'h404
`define FPR_OFF_RX_LEN       12'h405
`define FPR_BIT_CRC_BYPASS   0
`define FPR_BIT_AGC_HOLD     5
`define FPR_BIT_SKIP_PRE     6
`define FPR_PRE_LEVEL_HI     3
`define FPR_SYNC_LEN_HI      4
`define FPR_SYNC_TOL_HI      6
`define FPR_SYNC_TOL_LO      5
`define FPR_FC_HI            1
`define FPR_RST_PRE_CFG      8'h0C
`define FPR_RST_SYNC_CFG     8'h18
`define FPR_RST_QUAL         8'h01
`define FPR_RST_ZERO         8'h00
`define FPR_MODE_FSK_PKT     8'h04
`define FPR_FC_HOLD_QUAL     2'h3
`define FPR_PRE_PATTERN      24'hAAAAAA
`define FPR_PRE_PAIRS        4'hC
`define FPR_SEARCH_BITS      6'h20
`define FPR_CRC_INIT         16'h0000
`define FPR_CRC_POLY         16'h1021
`define FPR_EV_SYNC          0
`define FPR_EV_GOOD          1
`define FPR_EV_FRAME         2
`define FPR_EV_CRC_ERR       3
`endif

// ---- fpr_receiver.v ----
// GFSK/FSK packet-mode receive manager: preamble, sync word, payload store, CRC
// What this block does
// - Packet mode only when operation select is 4
// - Preamble mandatory unless bypass bit set, never written to store
// - Three-byte sliding window against 0xAA pattern
// - Pairs judged; only b10 is correct
// - Level field sets minimum correct pairs out of 12
// - Level drop before qualification restarts detection
// - Qualification byte count from host register
// - Freeze frequency correction on qualification, mode 3
// - Freeze gain on detection when bit set
// - Sync search four bytes, then store payload
// - Search timeout releases holds, back to preamble
// - Bypass bit disables preamble detection and qualification
// - Sync match gives byte alignment, sync stripped
// - Sync pattern MSB first from high register
// - Sync compare length 1 to 24 bits
// - Sync tolerance zero to three bit errors
// - Event on sync match; none for preamble
// - Payload first byte at start pointer
// - Bypass bit 0 verifies 16-bit CRC
// - Good CRC raises good-packet event, masked twice
// - Bypass 1 stores CRC, no good-packet event
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "fpr_defines.vh"
module fpr_receiver #(
    parameter AW = 8,
    parameter MAX_LEN = 8'hFF
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [13:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rx_bit,
    input  wire        rx_bit_valid,
    input  wire        rx_active,
    output reg         agc_hold,
    output reg         afc_hold,
    output reg         event_a,
    output reg         event_b,
    output reg         pkt_done
);
    localparam S_PRE  = 5'h01;
    localparam S_QUAL = 5'h02;
    localparam S_SYNC = 5'h04;
    localparam S_LEN  = 5'h08;
    localparam S_DATA = 5'h10;

    reg [7:0]  pkt_cfg_r, sync_lo_r, sync_mid_r, sync_hi_r, sync_cfg_r, pre_cfg_r;
    reg [7:0]  radio_cfg_r, corr_cfg_r, qual_cnt_r, fc_cfg_r, rx_base_r;
    reg [7:0]  mask_a_r, mask_b_r, ev_r, ram_ptr_r, rx_len_r;
    reg [7:0]  ram_r [0:(1<<AW)-1];
    reg [4:0]  state_r;
    reg [23:0] shreg_r;
    reg [2:0]  bitcnt_r;
    reg [7:0]  bytecnt_r;
    reg [5:0]  search_r;
    reg [7:0]  len_r;
    reg [7:0]  wptr_r;
    reg [15:0] crc_r;
    reg        in_pre_r;
    reg        pair_ph_r;

    wire        pkt_mode  = (radio_cfg_r == `FPR_MODE_FSK_PKT);
    wire        skip_pre  = pre_cfg_r[`FPR_BIT_SKIP_PRE];
    wire [3:0]  pre_level = pre_cfg_r[`FPR_PRE_LEVEL_HI:0];
    wire        crc_byp   = pkt_cfg_r[`FPR_BIT_CRC_BYPASS];
    wire [23:0] sh_nxt    = {shreg_r[22:0], rx_bit};
    wire [7:0]  byte_nxt  = sh_nxt[7:0];

    // Count b10 pairs over the 24-bit window, 12 pairs
    function [3:0] good_pairs;
        input [23:0] w;
        integer i;
        begin
            good_pairs = 4'h0;
            for (i = 0; i < 12; i = i + 1)
                if (w[2*i+1 +: 1] == 1'b1 && w[2*i] == 1'b0)
                    good_pairs = good_pairs + 4'h1;
        end
    endfunction

    // Mismatches over the low len bits; pattern is MSB-first from the high byte
    function [4:0] sync_errs;
        input [23:0] w;
        input [23:0] pat;
        input [4:0]  len;
        integer i;
        begin
            sync_errs = 5'h00;
            for (i = 0; i < 24; i = i + 1)
                if (i < len && w[i] != pat[i])
                    sync_errs = sync_errs + 5'h01;
        end
    endfunction

    function [15:0] crc_bit;
        input [15:0] c;
        input        b;
        begin
            crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `FPR_CRC_POLY : 16'h0000);
        end
    endfunction

    // Zero length would compare nothing; clamp to the 1..24 the window holds
    function [4:0] sync_len;
        input [4:0] f;
        begin
            if (f == 5'h00)
                sync_len = 5'h01;
            else if (f > 5'h18)
                sync_len = 5'h18;
            else
                sync_len = f;
        end
    endfunction

    // One decode for both directions, so reads and writes refuse the same holes
    function reg_mapped;
        input [11:0] idx;
        begin
            case (idx)
                `FPR_OFF_PKT_CFG,
                `FPR_OFF_SYNC_LO,
                `FPR_OFF_SYNC_MID,
                `FPR_OFF_SYNC_HI,
                `FPR_OFF_SYNC_CFG,
                `FPR_OFF_PRE_CFG,
                `FPR_OFF_RADIO_CFG,
                `FPR_OFF_CORR_CFG,
                `FPR_OFF_PRE_QUAL,
                `FPR_OFF_FC_CFG,
                `FPR_OFF_RX_BASE,
                `FPR_OFF_EV_MASK_A,
                `FPR_OFF_EV_MASK_B,
                `FPR_OFF_STATUS,
                `FPR_OFF_RAM_RD,
                `FPR_OFF_RX_LEN:    reg_mapped = 1'b1;
                default:            reg_mapped = 1'b0;
            endcase
        end
    endfunction

    wire [3:0]  pairs    = good_pairs(sh_nxt ^ `FPR_PRE_PATTERN ^ 24'hAAAAAA);
    wire        pre_hit  = (pre_level != 4'h0) && (pairs >= pre_level);
    wire [4:0]  slen     = sync_len(sync_cfg_r[`FPR_SYNC_LEN_HI:0]);
    // Right-align the pattern so the last-sent bit lands in the window's LSB
    wire [23:0] spat     = {sync_hi_r, sync_mid_r, sync_lo_r} >> (5'd24 - slen);
    wire        sync_hit = sync_errs(sh_nxt, spat, slen) <=
                           {3'h0, sync_cfg_r[`FPR_SYNC_TOL_HI:`FPR_SYNC_TOL_LO]};
    wire        byte_end = (bitcnt_r == 3'h7);
    // Events raised this cycle; they must survive a same-cycle W1C clear
    wire        eng_bit  = pkt_mode && rx_active && rx_bit_valid;
    wire        ev_syncw = eng_bit && (state_r == S_SYNC) && sync_hit;
    wire        pkt_end  = eng_bit && (state_r == S_DATA) && byte_end && (len_r == 8'h01) && !crc_byp;
    wire        crc_ok   = (crc_bit(crc_r, rx_bit) == 16'h0000);
    wire [7:0]  ev_set   = {4'h0, pkt_end && !crc_ok, ev_syncw, pkt_end && crc_ok, ev_syncw};
    wire        bus_acc  = psel && penable;
    wire [11:0] widx     = paddr[13:2];

    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_cfg_r   <= `FPR_RST_ZERO;
            sync_lo_r   <= `FPR_RST_ZERO;
            sync_mid_r  <= `FPR_RST_ZERO;
            sync_hi_r   <= `FPR_RST_ZERO;
            sync_cfg_r  <= `FPR_RST_SYNC_CFG;
            pre_cfg_r   <= `FPR_RST_PRE_CFG;
            radio_cfg_r <= `FPR_RST_ZERO;
            corr_cfg_r  <= `FPR_RST_ZERO;
            qual_cnt_r  <= `FPR_RST_QUAL;
            fc_cfg_r    <= `FPR_RST_ZERO;
            rx_base_r   <= `FPR_RST_ZERO;
            mask_a_r    <= `FPR_RST_ZERO;
            mask_b_r    <= `FPR_RST_ZERO;
            ev_r        <= `FPR_RST_ZERO;
            ram_ptr_r   <= `FPR_RST_ZERO;
            rx_len_r    <= `FPR_RST_ZERO;
            prdata      <= 32'h00000000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            agc_hold    <= 1'b0;
            afc_hold    <= 1'b0;
            event_a     <= 1'b0;
            event_b     <= 1'b0;
            pkt_done    <= 1'b0;
            state_r     <= S_PRE;
            shreg_r     <= 24'h000000;
            bitcnt_r    <= 3'h0;
            bytecnt_r   <= 8'h00;
            search_r    <= 6'h00;
            len_r       <= 8'h00;
            wptr_r      <= 8'h00;
            crc_r       <= `FPR_CRC_INIT;
            in_pre_r    <= 1'b0;
            pair_ph_r   <= 1'b0;
            for (k = 0; k < (1<<AW); k = k + 1)
                ram_r[k] <= 8'h00;
        end else begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            pkt_done <= 1'b0;
            event_a  <= |(ev_r & mask_a_r);
            event_b  <= |(ev_r & mask_b_r);

            // Receive engine; bus clear below is applied last, hardware set wins
            if (!pkt_mode || !rx_active) begin
                state_r  <= S_PRE;
                agc_hold <= 1'b0;
                afc_hold <= 1'b0;
                bitcnt_r <= 3'h0;
                in_pre_r  <= 1'b0;
                pair_ph_r <= 1'b0;
            end else if (rx_bit_valid) begin
                shreg_r  <= sh_nxt;
                bitcnt_r <= bitcnt_r + 3'h1;
                case (state_r)
                    S_PRE: begin
                        if (skip_pre) begin
                            state_r <= S_SYNC;
                        end else if (pre_hit) begin
                            state_r   <= S_QUAL;
                            bytecnt_r <= 8'h00;
                            pair_ph_r <= 1'b0;
                            bitcnt_r  <= 3'h0;
                            if (pre_cfg_r[`FPR_BIT_AGC_HOLD])
                                agc_hold <= 1'b1;
                        end
                    end
                    S_QUAL: begin
                        // Odd shifts of the pattern always read as 01 pairs; judge on pair ends only
                        pair_ph_r <= ~pair_ph_r;
                        if (pair_ph_r && !pre_hit) begin
                            state_r  <= S_PRE;
                            agc_hold <= 1'b0;
                        end else if (byte_end) begin
                            bytecnt_r <= bytecnt_r + 8'h01;
                            if (bytecnt_r + 8'h01 >= qual_cnt_r) begin
                                state_r <= S_SYNC;
                                search_r <= 6'h00;
                                in_pre_r <= 1'b1;
                                if (fc_cfg_r[`FPR_FC_HI:0] == `FPR_FC_HOLD_QUAL)
                                    afc_hold <= 1'b1;
                            end
                        end
                    end
                    S_SYNC: begin
                        // Window opens only once the preamble pattern stops
                        pair_ph_r <= ~pair_ph_r;
                        if (in_pre_r && pair_ph_r && !pre_hit)
                            in_pre_r <= 1'b0;
                        if (!in_pre_r && !skip_pre)
                            search_r <= search_r + 6'h01;
                        if (sync_hit) begin
                            state_r <= S_LEN;
                            bitcnt_r <= 3'h0;
                            crc_r   <= `FPR_CRC_INIT;
                            ev_r[`FPR_EV_SYNC]  <= 1'b1;
                            ev_r[`FPR_EV_FRAME] <= 1'b1;
                            wptr_r  <= rx_base_r;
                        end else if (!skip_pre && !in_pre_r &&
                                     search_r >= `FPR_SEARCH_BITS - 6'h01) begin
                            state_r  <= S_PRE;
                            agc_hold <= 1'b0;
                            afc_hold <= 1'b0;
                        end
                        // With bypass, no window bound applies
                    end
                    S_LEN: begin
                        crc_r <= crc_bit(crc_r, rx_bit);
                        if (byte_end) begin
                            len_r    <= byte_nxt;
                            rx_len_r <= byte_nxt;
                            ram_r[wptr_r[AW-1:0]] <= byte_nxt;
                            wptr_r   <= wptr_r + 8'h01;
                            // Empty or oversize frames must not leave the holds frozen
                            if (byte_nxt == 8'h00 || byte_nxt > MAX_LEN) begin
                                state_r  <= S_PRE;
                                agc_hold <= 1'b0;
                                afc_hold <= 1'b0;
                            end else begin
                                state_r  <= S_DATA;
                            end
                        end
                    end
                    S_DATA: begin
                        // CRC covers length, data and received check word
                        crc_r <= crc_bit(crc_r, rx_bit);
                        if (byte_end) begin
                            ram_r[wptr_r[AW-1:0]] <= byte_nxt;
                            wptr_r <= wptr_r + 8'h01;
                            len_r  <= len_r - 8'h01;
                            if (len_r == 8'h01) begin
                                state_r  <= S_PRE;
                                pkt_done <= 1'b1;
                                agc_hold <= 1'b0;
                                afc_hold <= 1'b0;
                                if (!crc_byp) begin
                                    if (crc_bit(crc_r, rx_bit) == 16'h0000)
                                        ev_r[`FPR_EV_GOOD] <= 1'b1;
                                    else
                                        ev_r[`FPR_EV_CRC_ERR] <= 1'b1;
                                end
                            end
                        end
                    end
                    default: state_r <= S_PRE;
                endcase
            end

            // APB slave: one wait state, answers in the second access cycle
            if (bus_acc && !pready) begin
                pready <= 1'b1;
                prdata <= 32'h00000000;
                pslverr <= !reg_mapped(widx);
                if (pwrite) begin
                    case (widx)
                        `FPR_OFF_PKT_CFG:   pkt_cfg_r   <= pwdata[7:0];
                        `FPR_OFF_SYNC_LO:   sync_lo_r   <= pwdata[7:0];
                        `FPR_OFF_SYNC_MID:  sync_mid_r  <= pwdata[7:0];
                        `FPR_OFF_SYNC_HI:   sync_hi_r   <= pwdata[7:0];
                        `FPR_OFF_SYNC_CFG:  sync_cfg_r  <= pwdata[7:0];
                        `FPR_OFF_PRE_CFG:   pre_cfg_r   <= pwdata[7:0];
                        `FPR_OFF_RADIO_CFG: radio_cfg_r <= pwdata[7:0];
                        `FPR_OFF_CORR_CFG:  corr_cfg_r  <= pwdata[7:0];
                        `FPR_OFF_PRE_QUAL:  qual_cnt_r  <= pwdata[7:0];
                        `FPR_OFF_FC_CFG:    fc_cfg_r    <= pwdata[7:0];
                        `FPR_OFF_RX_BASE:   rx_base_r   <= pwdata[7:0];
                        `FPR_OFF_EV_MASK_A: mask_a_r    <= pwdata[7:0];
                        `FPR_OFF_EV_MASK_B: mask_b_r    <= pwdata[7:0];
                        `FPR_OFF_STATUS:    ev_r        <= (ev_r & ~pwdata[7:0]) | ev_set;  // Set wins
                        `FPR_OFF_RAM_RD:    ram_ptr_r   <= pwdata[7:0];
                        `FPR_OFF_RX_LEN:    ;
                        default:            ;
                    endcase
                end else begin
                    case (widx)
                        `FPR_OFF_PKT_CFG:   prdata[7:0] <= pkt_cfg_r;
                        `FPR_OFF_SYNC_LO:   prdata[7:0] <= sync_lo_r;
                        `FPR_OFF_SYNC_MID:  prdata[7:0] <= sync_mid_r;
                        `FPR_OFF_SYNC_HI:   prdata[7:0] <= sync_hi_r;
                        `FPR_OFF_SYNC_CFG:  prdata[7:0] <= sync_cfg_r;
                        `FPR_OFF_PRE_CFG:   prdata[7:0] <= pre_cfg_r;
                        `FPR_OFF_RADIO_CFG: prdata[7:0] <= radio_cfg_r;
                        `FPR_OFF_CORR_CFG:  prdata[7:0] <= corr_cfg_r;
                        `FPR_OFF_PRE_QUAL:  prdata[7:0] <= qual_cnt_r;
                        `FPR_OFF_FC_CFG:    prdata[7:0] <= fc_cfg_r;
                        `FPR_OFF_RX_BASE:   prdata[7:0] <= rx_base_r;
                        `FPR_OFF_EV_MASK_A: prdata[7:0] <= mask_a_r;
                        `FPR_OFF_EV_MASK_B: prdata[7:0] <= mask_b_r;
                        `FPR_OFF_STATUS:    prdata[7:0] <= ev_r;
                        `FPR_OFF_RAM_RD: begin
                            prdata[7:0] <= ram_r[ram_ptr_r[AW-1:0]];
                            ram_ptr_r   <= ram_ptr_r + 8'h01;
                        end
                        `FPR_OFF_RX_LEN:    prdata[7:0] <= rx_len_r;
                        default:            ;
                    endcase
                end
            end
        end
    end
endmodule // fpr_receiver

// ---- fpr_receiver_properties.sv ----
// Concurrent checks on the packet receiver ports
`timescale 1ns/1ns
module fpr_receiver_props #(
    parameter AW = 8,
    parameter MAX_LEN = 8'hFF
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic rx_bit_valid,
    input logic agc_hold,
    input logic afc_hold,
    input logic pkt_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_take;
        psel && penable && !pready;
    endsequence
    // Bit strobes come four clocks apart, so three clocks still pins the cause
    sequence s_bit_lately;
        $past(rx_bit_valid) || $past(rx_bit_valid, 2) || $past(rx_bit_valid, 3);
    endsequence
    chk_ready_follows: assert property (s_take |=> pready)
        else $error("pready missing after access phase");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel && penable && !pready))
        else $error("pready without an access phase");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside a completion");
    chk_gain_on_bit: assert property ($rose(agc_hold) |-> s_bit_lately)
        else $error("gain hold rose without a received bit");
    chk_freq_on_bit: assert property ($rose(afc_hold) |-> s_bit_lately)
        else $error("frequency hold rose without a received bit");
    chk_done_on_bit: assert property (pkt_done |-> s_bit_lately)
        else $error("packet end without a received bit");
    chk_done_single: assert property (pkt_done |=> !pkt_done)
        else $error("packet end longer than one cycle");
endmodule // fpr_receiver_props
bind fpr_receiver fpr_receiver_props #(.AW(AW), .MAX_LEN(MAX_LEN)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(rx_bit_valid), .agc_hold(agc_hold), .afc_hold(afc_hold), .pkt_done(pkt_done));

// ---- fpr_link_tx.sv ----
// Remote transmitter model: frame bits MSB first, one bit every four clocks
`timescale 1ns/1ns
module fpr_link_tx (
    input  logic         pclk,
    input  logic         start,
    input  logic [255:0] frame,
    input  logic [8:0]   nbits,
    output logic         rx_bit = 1'b0,
    output logic         rx_bit_valid = 1'b0,
    output logic         busy = 1'b0
);
    logic [8:0] cnt = 9'h000;
    logic [1:0] div = 2'h0;
    always @(posedge pclk) begin
        div <= div + 2'h1;
        rx_bit_valid <= 1'b0;
        // Toggles between strobes so a stale bit is never mistaken for data
        rx_bit <= ~rx_bit;
        if (start) begin
            cnt <= nbits;
            busy <= 1'b1;
        end else if (busy && div == 2'h3) begin
            rx_bit <= frame[9'h0FF - (nbits - cnt)];
            rx_bit_valid <= 1'b1;
            cnt <= cnt - 9'h001;
            busy <= (cnt != 9'h001);
        end
    end
endmodule // fpr_link_tx

// ---- testbench.sv ----
// Self-checking bench for the packet receiver
`timescale 1ns/1ns
`include "fpr_defines.vh"
module testbench;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [13:0]  paddr = 14'h0000;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic         rx_active = 1'b1;
    logic         start = 1'b0;
    logic [255:0] frame = '0;
    logic [8:0]   nb = 9'h000;
    logic [31:0]  prdata;
    logic [31:0]  rdv;
    logic [31:0]  seed = 32'h0000_28FB;
    logic         pready, pslverr, rx_bit, rx_bit_valid, agc_hold, afc_hold, event_a, event_b, pkt_done, busy, err;
    logic [1:0]   seen_h;
    logic         seen_d;
    logic [7:0]   q[$];
    logic [11:0]  ci[10] = '{`FPR_OFF_RADIO_CFG, `FPR_OFF_SYNC_HI, `FPR_OFF_SYNC_MID, `FPR_OFF_SYNC_LO,
        `FPR_OFF_PRE_CFG, `FPR_OFF_FC_CFG, `FPR_OFF_PRE_QUAL, `FPR_OFF_RX_BASE, `FPR_OFF_EV_MASK_A, `FPR_OFF_EV_MASK_B};
    logic [7:0]   cv[10] = '{8'h04, 8'hF0, 8'hE1, 8'hC3, 8'h2C, 8'h03, 8'h02, 8'h20, 8'h02, 8'h01};
    int           failures = 0;
    int           comparisons = 0;

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        seen_h <= start ? 2'b00 : seen_h | {afc_hold, agc_hold};
        seen_d <= start ? 1'b0 : seen_d | pkt_done;
    end

    fpr_receiver uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .rx_active(rx_active), .agc_hold(agc_hold), .afc_hold(afc_hold),
        .event_a(event_a), .event_b(event_b), .pkt_done(pkt_done));
    fpr_link_tx link (.pclk(pclk), .start(start), .frame(frame), .nbits(nb), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .busy(busy));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `FPR_CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Idle edge at the end keeps back-to-back calls from driving psel twice at once
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40)
            failures++;
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [11:0] idx, input logic [7:0] exp, input string name);
        apb(1'b0, idx, 32'h0);
        check(name, rdv, {24'h0, exp});
    endtask
    task automatic put(input logic [7:0] b);
        frame[255 - int'(nb) -: 8] = b;
        nb = nb + 9'h008;
    endtask
    task automatic send(input int npre, input int serr, input logic bad);
        logic [23:0] s;
        logic [15:0] c;
        int          n;
        frame = '0;
        nb = 9'h000;
        c = 16'h0000;
        q.delete();
        s = {cv[1], cv[2], cv[3]} ^ ((24'h1 << serr) - 24'h1);
        repeat (npre) put(8'hAA);
        put(s[23:16]);
        put(s[15:8]);
        put(s[7:0]);
        n = int'(rnd() % 6) + 1;
        q.push_back(8'(n + 2));
        repeat (n) q.push_back(8'(rnd()));
        foreach (q[i]) c = crc(c, q[i]);
        q.push_back(c[15:8] ^ {7'h00, bad});
        q.push_back(c[7:0]);
        foreach (q[i]) put(q[i]);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (busy !== 1'b0 && n < 2000);
        if (n >= 2000)
            failures++;
        repeat (12) @(posedge pclk);
    endtask
    task automatic verify(input logic [7:0] st, input logic [1:0] hold, input logic byp);
        int k;
        rchk(`FPR_OFF_STATUS, st, "status");
        check("pkt_done", seen_d, st[0]);
        check("holds seen", seen_h, hold);
        check("holds now", {afc_hold, agc_hold}, 2'b00);
        check("events", {event_b, event_a}, {st[0], st[1]});
        if (st[0]) begin
            apb(1'b1, `FPR_OFF_RAM_RD, 32'h20);
            k = byp ? q.size() : q.size() - 2;
            for (int i = 0; i < k; i++)
                rchk(`FPR_OFF_RAM_RD, q[i], "ram");
        end
        apb(1'b1, `FPR_OFF_STATUS, 32'hFF);
    endtask

    initial begin
        #400000;
        failures++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`FPR_OFF_PRE_CFG, 8'h0C, "pre cfg");
        rchk(`FPR_OFF_SYNC_CFG, 8'h18, "sync cfg");
        rchk(`FPR_OFF_PRE_QUAL, 8'h01, "qual");
        rchk(`FPR_OFF_PKT_CFG, 8'h00, "pkt cfg");
        rchk(12'h7FF, 8'h00, "unmapped");
        check("slverr", err, 1'b1);
        foreach (ci[i]) apb(1'b1, ci[i], {24'h0, cv[i]});
        rchk(`FPR_OFF_SYNC_HI, 8'hF0, "sync hi");
        apb(1'b1, `FPR_OFF_CORR_CFG, 32'h0D);
        rchk(`FPR_OFF_CORR_CFG, 8'h0D, "corr cfg");
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, `FPR_OFF_SYNC_CFG, 32'h18 | (t << 5));
            send(6, t, 1'b0);
            verify(8'h07, 2'b11, 1'b0);
        end
        apb(1'b1, `FPR_OFF_SYNC_CFG, 32'h18);
        send(6, 1, 1'b0);
        verify(8'h00, 2'b11, 1'b0);
        send(6, 0, 1'b1);
        verify(8'h0D, 2'b11, 1'b0);
        apb(1'b1, `FPR_OFF_FC_CFG, 32'h0);
        send(6, 0, 1'b0);
        verify(8'h07, 2'b01, 1'b0);
        apb(1'b1, `FPR_OFF_FC_CFG, 32'h3);
        apb(1'b1, `FPR_OFF_PKT_CFG, 32'h1);
        send(6, 0, 1'b0);
        verify(8'h05, 2'b11, 1'b1);
        apb(1'b1, `FPR_OFF_PRE_CFG, 32'h6C);
        send(0, 0, 1'b0);
        verify(8'h05, 2'b00, 1'b1);
        apb(1'b1, `FPR_OFF_PRE_CFG, 32'h20);
        send(6, 0, 1'b0);
        verify(8'h00, 2'b00, 1'b0);
        apb(1'b1, `FPR_OFF_PRE_CFG, 32'h2C);
        apb(1'b1, `FPR_OFF_RADIO_CFG, 32'h0);
        send(6, 0, 1'b0);
        verify(8'h00, 2'b00, 1'b0);
        test_done;
    end
endmodule // testbench
